// [intr_ctrl.sv]
// What this block does
// (R1) Bus reset sets event bit 17
// (R2) Node id stream done sets bit 16
// (R3) Bus reset event clears bit 16 unless node id done fires with it
// (R4) Event bits 15 to 10 read zero
// (R5) Unacked lock response sets bit 9
// (R6) Host write error sets bit 8
// (R7) Bit 7 is live iso receive summary
// (R8) Bit 6 is live iso transmit summary
// (R9) Response packet stored sets bit 5
// (R10) Request packet stored sets bit 4
// (R11) Receive response descriptor done sets bit 3
// (R12) Receive request descriptor done sets bit 2
// (R13) Response transmit done sets bit 1
// (R14) Request transmit done sets bit 0
// (R15) Mask ports at 88h, 8Ch read mask
// (R16) Mask bit enables same event bit
// (R17) Bit 31 gates all external interrupts
// (R18) Mask bit 30 gates maker event
// (R19) Ones set or clear, zeros ignored
// (R20) Event ports 80h, 84h; clear reads masked
// (R21) Interrupt when enabled event and global
// (R22) Reserved mask bits read zero
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

module intr_ctrl
    import intr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // Event sources, one-cycle pulses
    input wire event_src_t src_i,
    // Isochronous channel interrupt levels
    input wire logic [7:0] iso_tx_chan_i,
    input wire logic [7:0] iso_rx_chan_i,
    // Interrupt
    output logic irq_o
);

    // ************************************************************
    // Bus decode
    // ************************************************************
    bus_state_t state_r; // Slave state
    logic [31:0] dat_r; // Read data
    logic ack_r; // Ack flag
    logic err_r; // Error flag
    logic irq_r; // Interrupt output
    logic [31:0] evt_r; // Latched event bits
    logic [31:0] msk_r; // Mask bits

    // Byte-lane expansion of write data
    function automatic logic [31:0] lane(input logic [31:0] d, input logic [3:0] s);
        lane = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // Request taken only while the slave is idle
    wire req = cyc_i && stb_i && (state_r == BUS_IDLE);
    // Write strobe, one cycle per accepted write
    wire wr = req && we_i;
    // Write data with unselected lanes forced to zero
    wire [31:0] wd = lane(dat_i, sel_i);
    // Address match per port
    wire hit_es = (adr_i == EVT_SET_ADDR);
    wire hit_ec = (adr_i == EVT_CLR_ADDR);
    wire hit_ms = (adr_i == MSK_SET_ADDR);
    wire hit_mc = (adr_i == MSK_CLR_ADDR);
    // Isochronous ports, low byte only
    wire hit_txe = (adr_i == ISO_TX_EVT_ADDR);
    wire hit_txes = (adr_i == ISO_TX_EVT_CLR_ADDR);
    wire hit_txm = (adr_i == ISO_TX_MSK_ADDR);
    wire hit_txms = (adr_i == ISO_TX_MSK_CLR_ADDR);
    wire hit_rxe = (adr_i == ISO_RX_EVT_ADDR);
    wire hit_rxes = (adr_i == ISO_RX_EVT_CLR_ADDR);
    wire hit_rxm = (adr_i == ISO_RX_MSK_ADDR);
    wire hit_rxms = (adr_i == ISO_RX_MSK_CLR_ADDR);
    // Any mapped port; the rest answer with err
    wire hit_any = hit_es || hit_ec || hit_ms || hit_mc || hit_txe || hit_txes
        || hit_txm || hit_txms || hit_rxe || hit_rxes || hit_rxm || hit_rxms;

    // ************************************************************
    // Isochronous summaries
    // ************************************************************
    wire [7:0] tx_evt;
    wire [7:0] tx_msk;
    wire [7:0] rx_evt;
    wire [7:0] rx_msk;
    wire tx_sum;
    wire rx_sum;

    // Transmit channels
    iso_summary u_tx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .evt_set_i(wr && hit_txe),
        .evt_clr_i(wr && hit_txes),
        .msk_set_i(wr && hit_txm),
        .msk_clr_i(wr && hit_txms),
        .wdata_i(wd[7:0]),
        .chan_i(iso_tx_chan_i),
        .evt_o(tx_evt),
        .msk_o(tx_msk),
        .summary_o(tx_sum)
    );

    // Receive channels
    iso_summary u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .evt_set_i(wr && hit_rxe),
        .evt_clr_i(wr && hit_rxes),
        .msk_set_i(wr && hit_rxm),
        .msk_clr_i(wr && hit_rxms),
        .wdata_i(wd[7:0]),
        .chan_i(iso_rx_chan_i),
        .evt_o(rx_evt),
        .msk_o(rx_msk),
        .summary_o(rx_sum)
    );

    // ************************************************************
    // Event register
    // ************************************************************
    // Hardware set vector
    wire [31:0] hw_set = (32'(src_i.bus_reset_event) << BIT_BUS_RESET) // R1
        | (32'(src_i.node_identification_done_event) << BIT_NODE_ID) // R2
        | (32'(src_i.lock_reply_error_event) << BIT_LOCK_ERR) // R5
        | (32'(src_i.buffered_write_error_event) << BIT_WR_ERR) // R6
        | (32'(src_i.response_packet_received) << BIT_RSP_PKT) // R9
        | (32'(src_i.request_packet_received) << BIT_REQ_PKT) // R10
        | (32'(src_i.async_rx_response_done) << BIT_RX_RSP_DONE) // R11
        | (32'(src_i.async_rx_request_done) << BIT_RX_REQ_DONE) // R12
        | (32'(src_i.response_send_done) << BIT_RSP_SEND) // R13
        | (32'(src_i.request_send_done) << BIT_REQ_SEND) // R14
        | (32'(src_i.maker_defined_event) << BIT_MAKER);
    // Software set and clear strobes
    wire [31:0] sw_set = (wr && hit_es) ? wd : 32'h0000_0000; // R19
    wire [31:0] sw_clr = (wr && hit_ec) ? wd : 32'h0000_0000; // R19
    // Bus reset forces node id done off in the same cycle unless node id done fires with it
    wire [31:0] rst_kill = src_i.bus_reset_event ? (32'h1 << BIT_NODE_ID) : 32'h0; // R3
    wire [31:0] evt_lat = (32'h1 << BIT_MAKER) | EVT_LATCH_MASK;
    wire [31:0] evt_nxt = ((((evt_r & ~sw_clr) | sw_set) & ~rst_kill) | hw_set) & evt_lat; // R4
    // Visible event word with live summaries
    wire [31:0] evt_view = evt_r | (32'(rx_sum) << BIT_ISO_RX) // R7
        | (32'(tx_sum) << BIT_ISO_TX); // R8

    // ************************************************************
    // Mask register
    // ************************************************************
    // Software set and clear of mask bits
    wire [31:0] m_set = (wr && hit_ms) ? wd : 32'h0000_0000; // R19
    wire [31:0] m_clr = (wr && hit_mc) ? wd : 32'h0000_0000; // R19
    wire [31:0] msk_nxt = ((msk_r & ~m_clr) | m_set) & MSK_RW_MASK; // R22
    // Enabled events, global bit excluded
    wire [30:0] active = evt_view[30:0] & msk_r[30:0]; // R16 R18
    wire irq_nxt = msk_r[BIT_GLOBAL_EN] && (|active); // R17 R21

    // ************************************************************
    // Read data select
    // ************************************************************
    wire [31:0] rd_nxt = hit_es ? evt_view
        : hit_ec ? (evt_view & msk_r) // R20
        : (hit_ms || hit_mc) ? msk_r // R15
        : (hit_txe || hit_txes) ? {24'h0, tx_evt}
        : (hit_txm || hit_txms) ? {24'h0, tx_msk}
        : (hit_rxe || hit_rxes) ? {24'h0, rx_evt}
        : (hit_rxm || hit_rxms) ? {24'h0, rx_msk}
        : 32'h0000_0000;

    // Event and mask storage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_r <= EVT_RESET;
            msk_r <= MSK_RESET;
            irq_r <= 1'b0;
        end else begin
            evt_r <= evt_nxt;
            msk_r <= msk_nxt;
            irq_r <= irq_nxt;
        end
    end

    // Bus slave, ack or err one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= BUS_IDLE;
            ack_r <= 1'b0;
            err_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            case (state_r)
                BUS_IDLE: begin
                    if (req) begin
                        state_r <= BUS_ACK;
                        ack_r <= hit_any;
                        err_r <= !hit_any;
                        dat_r <= we_i ? 32'h0000_0000 : rd_nxt;
                    end
                end
                default: begin
                    state_r <= BUS_IDLE;
                    ack_r <= 1'b0;
                    err_r <= 1'b0;
                end
            endcase
        end
    end

    // Outputs straight from flip-flops
    assign dat_o = dat_r;
    assign ack_o = ack_r;
    assign err_o = err_r;
    assign irq_o = irq_r;

    // ************************************************************
    // Checks
    // ************************************************************
    bus_reset_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        src_i.bus_reset_event |=> evt_r[BIT_BUS_RESET])
        else $error("bus reset bit not set");
    node_id_kill_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        src_i.bus_reset_event && !src_i.node_identification_done_event
        |=> !evt_r[BIT_NODE_ID])
        else $error("node id bit survived bus reset");
    node_id_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        src_i.node_identification_done_event |=> evt_r[BIT_NODE_ID])
        else $error("node id bit not set");
    resv_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        evt_r[15:10] == 6'h00 && msk_r[29:27] == 3'h0 && !msk_r[18])
        else $error("reserved bits nonzero");
    lock_err_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        src_i.lock_reply_error_event |=> evt_r[BIT_LOCK_ERR])
        else $error("lock error bit not set");
    send_done_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        src_i.request_send_done |=> evt_r[BIT_REQ_SEND])
        else $error("request send bit not set");
    global_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        !msk_r[BIT_GLOBAL_EN] |=> !irq_o)
        else $error("interrupt without global enable");
    irq_raise_a: assert property (@(posedge clk_i) disable iff (rst_i) // R21
        msk_r[BIT_GLOBAL_EN] && (|(evt_r[30:0] & msk_r[30:0])) |=> irq_o)
        else $error("interrupt missing");
    mask_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
        wr && hit_ms && wd[BIT_WR_ERR] |=> msk_r[BIT_WR_ERR])
        else $error("mask set lost");
    mask_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        req && !we_i && hit_mc |=> ack_o && dat_o == $past(msk_r))
        else $error("mask read wrong");

    // ************************************************************
    // Event source checks
    // ************************************************************
    // Host write error latches
    write_err_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        src_i.buffered_write_error_event |=> evt_r[BIT_WR_ERR])
        else $error("write error bit not set");
    // Stored response packet latches
    rsp_pkt_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        src_i.response_packet_received |=> evt_r[BIT_RSP_PKT])
        else $error("response packet bit not set");
    // Stored request packet latches
    req_pkt_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        src_i.request_packet_received |=> evt_r[BIT_REQ_PKT])
        else $error("request packet bit not set");
    // Receive response descriptor done latches
    rx_rsp_done_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        src_i.async_rx_response_done |=> evt_r[BIT_RX_RSP_DONE])
        else $error("receive response bit not set");
    // Receive request descriptor done latches
    rx_req_done_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        src_i.async_rx_request_done |=> evt_r[BIT_RX_REQ_DONE])
        else $error("receive request bit not set");
    // Response transmit done latches
    rsp_send_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        src_i.response_send_done |=> evt_r[BIT_RSP_SEND])
        else $error("response send bit not set");
    // Software set of an event bit lands
    evt_set_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
        wr && hit_es && wd[BIT_REQ_PKT] |=> evt_r[BIT_REQ_PKT])
        else $error("event set lost");
    // Software clear of an event bit lands
    evt_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
        wr && hit_ec && wd[BIT_LOCK_ERR] && !src_i.lock_reply_error_event
        |=> !evt_r[BIT_LOCK_ERR])
        else $error("event clear lost");

    // ************************************************************
    // Read path checks
    // ************************************************************
    // Mapped port answers with ack one cycle later
    ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        req && hit_any |=> ack_o && !err_o)
        else $error("ack missing");
    // Answer stands for one cycle only
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        ack_o |=> !ack_o && !err_o)
        else $error("ack held too long");
    // Unmapped port answers with err
    err_decode_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        req && !hit_any |=> err_o && !ack_o)
        else $error("err missing");
    // Reserved event bits read zero
    resv_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        req && !we_i && hit_es |=> dat_o[15:10] == 6'h00)
        else $error("reserved event bits read nonzero");
    // Clear port reads events combined with mask
    clr_read_a: assert property (@(posedge clk_i) disable iff (rst_i) // R20
        req && !we_i && hit_ec |=> dat_o == ($past(evt_view) & $past(msk_r)))
        else $error("clear port read wrong");
    // Live receive summary on read
    iso_rx_live_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        req && !we_i && hit_es |=> dat_o[BIT_ISO_RX] == |($past(rx_evt) & $past(rx_msk)))
        else $error("receive summary wrong");
    // Live transmit summary on read
    iso_tx_live_a: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        req && !we_i && hit_es |=> dat_o[BIT_ISO_TX] == |($past(tx_evt) & $past(tx_msk)))
        else $error("transmit summary wrong");

    // ************************************************************
    // Mask and interrupt checks
    // ************************************************************
    // Reserved mask bits read zero
    resv_mask_a: assert property (@(posedge clk_i) disable iff (rst_i) // R22
        req && !we_i && (hit_ms || hit_mc)
        |=> dat_o[29:27] == 3'h0 && !dat_o[18] && dat_o[15:10] == 6'h00)
        else $error("reserved mask bits read nonzero");
    // Software clear of a mask bit lands
    mask_clear_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
        wr && hit_mc && wd[BIT_LOCK_ERR] |=> !msk_r[BIT_LOCK_ERR])
        else $error("mask clear lost");
    // Unselected lane leaves mask bit alone
    zero_lane_a: assert property (@(posedge clk_i) disable iff (rst_i) // R19
        wr && hit_ms && !sel_i[1] && !msk_r[BIT_WR_ERR] |=> !msk_r[BIT_WR_ERR])
        else $error("unselected lane wrote mask");
    // No enabled event, no interrupt
    mask_enable_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        !(|(evt_view[30:0] & msk_r[30:0])) |=> !irq_o)
        else $error("interrupt from masked event");
    // Maker event needs its own mask bit
    maker_gate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
        !msk_r[BIT_MAKER] && !(|(evt_view[29:0] & msk_r[29:0])) |=> !irq_o)
        else $error("maker event not gated");

endmodule

`default_nettype wire

// [intr_pkg.sv]
package intr_pkg;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] EVT_SET_ADDR = 8'h80;
    localparam logic [7:0] EVT_CLR_ADDR = 8'h84;
    localparam logic [7:0] MSK_SET_ADDR = 8'h88;
    localparam logic [7:0] MSK_CLR_ADDR = 8'h8C;
    localparam logic [7:0] ISO_TX_EVT_ADDR = 8'h90;
    localparam logic [7:0] ISO_TX_MSK_ADDR = 8'h98;
    localparam logic [7:0] ISO_RX_EVT_ADDR = 8'hA0;
    localparam logic [7:0] ISO_RX_MSK_ADDR = 8'hA8;
    localparam logic [7:0] ISO_TX_EVT_CLR_ADDR = 8'h94;
    localparam logic [7:0] ISO_TX_MSK_CLR_ADDR = 8'h9C;
    localparam logic [7:0] ISO_RX_EVT_CLR_ADDR = 8'hA4;
    localparam logic [7:0] ISO_RX_MSK_CLR_ADDR = 8'hAC;

    // ************************************************************
    // Event bit positions
    // ************************************************************
    localparam int BIT_REQ_SEND = 0;
    localparam int BIT_RSP_SEND = 1;
    localparam int BIT_RX_REQ_DONE = 2;
    localparam int BIT_RX_RSP_DONE = 3;
    localparam int BIT_REQ_PKT = 4;
    localparam int BIT_RSP_PKT = 5;
    localparam int BIT_ISO_TX = 6;
    localparam int BIT_ISO_RX = 7;
    localparam int BIT_WR_ERR = 8;
    localparam int BIT_LOCK_ERR = 9;
    localparam int BIT_NODE_ID = 16;
    localparam int BIT_BUS_RESET = 17;
    localparam int BIT_MAKER = 30;
    localparam int BIT_GLOBAL_EN = 31;

    // ************************************************************
    // Writable bit masks and reset values
    // ************************************************************
    localparam logic [31:0] EVT_LATCH_MASK = 32'h0003_033F;
    localparam logic [31:0] MSK_RW_MASK = 32'hC003_03FF;
    localparam logic [7:0] ISO_RW_MASK = 8'hFF;
    localparam logic [31:0] EVT_RESET = 32'h0000_0000;
    localparam logic [31:0] MSK_RESET = 32'h0000_0000;
    localparam logic [7:0] ISO_RESET = 8'h00;

    // ************************************************************
    // Event source bundle
    // ************************************************************
    typedef struct packed {
        logic maker_defined_event;
        logic bus_reset_event;
        logic node_identification_done_event;
        logic lock_reply_error_event;
        logic buffered_write_error_event;
        logic response_packet_received;
        logic request_packet_received;
        logic async_rx_response_done;
        logic async_rx_request_done;
        logic response_send_done;
        logic request_send_done;
    } event_src_t;

    // Bus slave states
    typedef enum logic {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;

endpackage

// [iso_summary.sv]
`timescale 1ns/100ps
`default_nettype none

// ************************************************************
// Per-channel isochronous event and mask pair with summary
// ************************************************************
module iso_summary
    import intr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Software access
    input wire logic evt_set_i,
    input wire logic evt_clr_i,
    input wire logic msk_set_i,
    input wire logic msk_clr_i,
    input wire logic [7:0] wdata_i,
    // Channel interrupt levels
    input wire logic [7:0] chan_i,
    // State
    output logic [7:0] evt_o,
    output logic [7:0] msk_o,
    output logic summary_o
);

    logic [7:0] evt_r; // Sticky channel events
    logic [7:0] msk_r; // Channel enables
    logic [7:0] chan_d_r; // Previous channel level
    wire [7:0] rise = chan_i & ~chan_d_r;
    wire [7:0] evt_nxt = ((evt_r & ~(evt_clr_i ? wdata_i : 8'h00))
        | (evt_set_i ? wdata_i : 8'h00) | rise) & ISO_RW_MASK;
    wire [7:0] msk_nxt = ((msk_r & ~(msk_clr_i ? wdata_i : 8'h00))
        | (msk_set_i ? wdata_i : 8'h00)) & ISO_RW_MASK;

    // Edge set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_r <= ISO_RESET;
            msk_r <= ISO_RESET;
            chan_d_r <= ISO_RESET;
        end else begin
            evt_r <= evt_nxt;
            msk_r <= msk_nxt;
            chan_d_r <= chan_i;
        end
    end

    assign evt_o = evt_r;
    assign msk_o = msk_r;
    assign summary_o = |(evt_r & msk_r);

endmodule

`default_nettype wire

// [wb_host.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************
// Host software model: classic bus master
// ****************
module wb_host (
    // Clock
    input wire logic clk_i,
    // Request
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o,
    // Answer
    input wire logic [31:0] dat_i,
    input wire logic ack_i,
    input wire logic err_i
);
    // Bus idle at time zero
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end

    // One cycle, held until ack or err is sampled
    task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q, output logic e);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        @(posedge clk_i);
        // Wait for the answer; only the bench watchdog ends a hang
        while (ack_i !== 1'b1 && err_i !== 1'b1) begin
            @(posedge clk_i);
        end
        q = dat_i;
        e = err_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) check(got, exp)

// ****************
// Self-checking bench for the interrupt block
// ****************
module testbench
    import intr_pkg::*;
;
    // Event bit of each source field, low field first
    localparam int POS[11] = '{0, 1, 2, 3, 4, 5, 8, 9, 16, 17, 30};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    event_src_t src = '0;
    logic [7:0] iso_tx = 8'h00;
    logic [7:0] iso_rx = 8'h00;
    logic cyc, stb, we, ack, err, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    int n_mismatch = 0;
    int n_tests = 0;

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    intr_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err),
        .src_i(src), .iso_tx_chan_i(iso_tx), .iso_rx_chan_i(iso_rx), .irq_o(irq));

    wb_host i_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
        .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack), .err_i(err));

    // Verdict and end of run
    task automatic print_verdict;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Bus shortcuts
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        logic e;
        i_host.xfer(1'b1, a, s, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        i_host.xfer(1'b0, a, 4'hF, 32'h0, q, e);
    endtask

    // One-cycle source pulse
    task automatic pulse(input logic [10:0] v);
        @(posedge clk_i);
        src <= event_src_t'(v);
        @(posedge clk_i);
        src <= '0;
    endtask

    // Byte lanes as a bit mask
    function automatic logic [31:0] lanes(input logic [3:0] s);
        lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    // Latched events after a pulse; bus reset drops node id unless node id pulses with it
    function automatic logic [31:0] next_ev(input logic [31:0] ev, input logic [10:0] v);
        next_ev = ev;
        for (int i = 0; i < 11; i++) begin
            if (v[i]) begin
                next_ev[POS[i]] = 1'b1;
            end
        end
        if (v[9] && !v[8]) begin
            next_ev[16] = 1'b0;
        end
    endfunction

    // Watchdog
    initial begin
        #(100 * 20000);
        n_mismatch++;
        print_verdict();
    end

    // Main sequence
    initial begin
        logic [31:0] q, ev, m, d;
        logic [10:0] sv;
        logic [7:0] a, mm;
        logic [3:0] s;
        logic e;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        void'($urandom(2434));
        ev = 32'h0;
        m = 32'h0;
        // Reset values, then a refused address
        for (int k = 0; k < 4; k++) begin
            rd(8'(EVT_SET_ADDR + 4 * k), q);
            `CHK(q, 32'h0);
        end
        i_host.xfer(1'b0, 8'h40, 4'hF, 32'h0, q, e);
        `CHK({31'h0, e}, 32'h1);
        // Software set of every event bit but maker bit 30; reserved stay zero
        wr(EVT_SET_ADDR, 32'hBFFF_FFFF, 4'hF);
        rd(EVT_SET_ADDR, q);
        `CHK(q, EVT_LATCH_MASK);
        wr(EVT_CLR_ADDR, 32'hFFFF_FFFF, 4'hF);
        // Random mask traffic, source pulses and clears
        for (int k = 0; k < 24; k++) begin
            d = $urandom;
            s = 4'($urandom);
            wr(MSK_SET_ADDR, d, s);
            m = m | (d & lanes(s) & MSK_RW_MASK);
            rd(MSK_SET_ADDR, q);
            `CHK(q, m);
            d = $urandom;
            wr(MSK_CLR_ADDR, d, 4'hF);
            m = m & ~d;
            rd(MSK_CLR_ADDR, q);
            `CHK(q, m);
            sv = 11'($urandom);
            pulse(sv);
            ev = next_ev(ev, sv);
            rd(EVT_SET_ADDR, q);
            `CHK(q, ev);
            rd(EVT_CLR_ADDR, q);
            `CHK(q, ev & m);
            `CHK({31'h0, irq}, {31'h0, m[31] && |(ev & m & 32'h7FFF_FFFF)});
            d = $urandom;
            wr(EVT_CLR_ADDR, d, 4'hF);
            ev = ev & ~d;
        end
        // Live isochronous summaries, transmit then receive
        for (int k = 0; k < 2; k++) begin
            a = (k == 0) ? ISO_TX_EVT_ADDR : ISO_RX_EVT_ADDR;
            d = {24'h0, 8'($urandom) | 8'h01};
            mm = 8'($urandom);
            @(posedge clk_i);
            if (k == 0) begin
                iso_tx <= d[7:0];
            end else begin
                iso_rx <= d[7:0];
            end
            wr(8'(a + 8'h08), {24'h0, mm}, 4'hF);
            rd(a, q);
            `CHK(q, d);
            rd(8'(a + 8'h08), q);
            `CHK(q, {24'h0, mm});
            rd(EVT_SET_ADDR, q);
            `CHK({31'h0, q[6 + k]}, {31'h0, |(d[7:0] & mm)});
            wr(8'(a + 8'h0C), 32'h0000_00FF, 4'hF);
            rd(EVT_SET_ADDR, q);
            `CHK({31'h0, q[6 + k]}, 32'h0);
        end
        // Reset again in mid-run; registers return to zero
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(MSK_SET_ADDR, q);
        `CHK(q, 32'h0);
        rd(EVT_SET_ADDR, q);
        `CHK(q, 32'h0);
        `CHK({31'h0, irq}, 32'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
